// [rtl/mau_pkg.sv]
// Purpose: Shared constants and types for the multiply-accumulate unit
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes: Instruction words arrive left-justified, first opcode byte in bits 31:24

// ********************************************************************
// Package
// ********************************************************************
package mau_pkg;

   // Register byte offsets
   localparam logic [7:0] MAU_CTRL_OFS = 8'h00;
   localparam logic [7:0] MAU_OVF_OFS = 8'h04;
   localparam logic [7:0] MAU_ACC_BASE_OFS = 8'h10;   // Low word at +8n, guard bits at +8n+4
   localparam logic [7:0] MAU_TMP_BASE_OFS = 8'h30;   // Temp register n at +4n

   // Control register fields
   localparam int MAU_FRACT_BIT = 0;
   localparam int MAU_MULSAT_BIT = 1;
   localparam int MAU_RNDMODE_BIT = 2;
   localparam int MAU_WIDE_BIT = 3;
   localparam int MAU_DPSAT_BIT = 4;
   localparam int MAU_LEGACY_BIT = 5;
   localparam int MAU_CTRL_W = 6;
   localparam logic [5:0] MAU_CTRL_RST = 6'h00;

   // Datapath widths and constants
   localparam int MAU_ACC_W = 40;
   localparam int MAU_OP_W = 17;
   localparam logic [16:0] MAU_OP_MIN = 17'h18000;
   localparam logic [31:0] MAU_PROD_MAX = 32'h7FFFFFFF;
   localparam logic [40:0] MAU_RND_HALF = 41'h00000008000;
   localparam logic [15:0] MAU_HALF_LSB = 16'h8000;
   localparam logic [39:0] MAU_SAT40_POS = 40'h7FFFFFFFFF;
   localparam logic [39:0] MAU_SAT40_NEG = 40'h8000000000;
   localparam logic [39:0] MAU_SAT32_POS = 40'h007FFFFFFF;
   localparam logic [39:0] MAU_SAT32_NEG = 40'hFF80000000;

   // Leading opcode patterns
   localparam logic [6:0] MAU_OPC_ACC_TMP = 7'h2B;    // 0101 011E
   localparam logic [6:0] MAU_OPC_DST_TMP = 7'h2C;    // 0101 100E
   localparam logic [6:0] MAU_OPC_SHORT = 7'h0F;      // 0001 111E
   localparam logic [7:0] MAU_OPC_LONG = 8'h79;
   localparam logic [7:0] MAU_OPC_COEF = 8'hD1;
   localparam logic [7:0] MAU_OPC_MEM = 8'hD2;
   localparam logic [1:0] MAU_SUB_COEF = 2'b01;
   localparam logic [1:0] MAU_SUB_MEM = 2'b00;

   // Instruction sizes in bytes
   localparam logic [2:0] MAU_SIZE_REG = 3'h2;
   localparam logic [2:0] MAU_SIZE_SHORT = 3'h3;
   localparam logic [2:0] MAU_SIZE_LONG = 3'h4;
   localparam logic [2:0] MAU_SIZE_MEM = 3'h3;

   typedef enum logic [2:0] {
      MAU_FORM_NONE = 3'b000,
      MAU_FORM_ACC_TMP = 3'b001,
      MAU_FORM_DST_TMP = 3'b010,
      MAU_FORM_SHORT = 3'b011,
      MAU_FORM_LONG = 3'b100,
      MAU_FORM_COEF = 3'b101,
      MAU_FORM_MEM = 3'b110
   } mau_form_e;

endpackage

// [rtl/mau_core.sv]
// Purpose: Single-cycle multiply-accumulate unit with AHB-Lite register access
// Assumes: Decoder presents one instruction word per cycle with its memory operands
// Notes: Four 40-bit accumulators and four 16-bit temp registers live here

`timescale 1ns/1ns

module mau_core (
   input wire logic clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Instruction issue from the decoder
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic [15:0] smem_data,
   input wire logic [15:0] cmem_data,
   output logic instr_legal,
   output logic [2:0] instr_size,
   output logic instr_pairable,
   // Result
   output logic result_valid,
   output logic [1:0] result_dst,
   output logic [39:0] result_value,
   output logic result_overflow,
   output logic [3:0] acc_overflow_flags
);
   // ********************************************************************
   // State
   // ********************************************************************
   logic [39:0] acc_q [4];
   logic [15:0] tmp_q [4];
   logic [3:0] ovf_q;
   logic [5:0] ctrl_q;
   logic dp_valid_q, dp_write_q, rd_done_q, res_valid_q, res_ovf_q;
   logic [7:0] dp_addr_q;
   logic [31:0] hrdata_q;
   logic [1:0] res_dst_q;
   logic [39:0] res_value_q;
   // Mode bits are plain taps of the control register
   wire logic fractional_mode = ctrl_q[mau_pkg::MAU_FRACT_BIT];
   wire logic multiply_saturation_mode = ctrl_q[mau_pkg::MAU_MULSAT_BIT];
   wire logic rounding_mode_select = ctrl_q[mau_pkg::MAU_RNDMODE_BIT];
   wire logic wide_overflow_mode = ctrl_q[mau_pkg::MAU_WIDE_BIT];
   wire logic datapath_saturation_enable = ctrl_q[mau_pkg::MAU_DPSAT_BIT];
   wire logic legacy_compat_mode = ctrl_q[mau_pkg::MAU_LEGACY_BIT];
   // ********************************************************************
   // Decode
   // ********************************************************************
   mau_pkg::mau_form_e form;
   logic [1:0] fld_src, fld_dst, fld_tmp;
   logic round_opt, t3_copy;
   // Opcode byte selects the form; field positions differ per form, except between the two register forms
   always_comb begin
      form = mau_pkg::MAU_FORM_NONE;
      fld_src = 2'h0;
      fld_dst = 2'h0;
      fld_tmp = 2'h0;
      round_opt = 1'b0;
      t3_copy = 1'b0;
      instr_size = 3'h0;
      instr_pairable = 1'b0;
      // Both register forms share their field layout; bit 17 tells them apart
      if ((instr_word[31:25] == mau_pkg::MAU_OPC_ACC_TMP && !instr_word[17])
          || (instr_word[31:25] == mau_pkg::MAU_OPC_DST_TMP && instr_word[17])) begin
         form = instr_word[17] ? mau_pkg::MAU_FORM_DST_TMP : mau_pkg::MAU_FORM_ACC_TMP;
         fld_dst = instr_word[23:22];
         fld_src = instr_word[21:20];
         fld_tmp = instr_word[19:18];
         round_opt = instr_word[16];
         instr_size = mau_pkg::MAU_SIZE_REG;
         instr_pairable = 1'b1;
      end else if (instr_word[31:25] == mau_pkg::MAU_OPC_SHORT && instr_word[9]) begin
         form = mau_pkg::MAU_FORM_SHORT;
         fld_src = instr_word[15:14];
         fld_dst = instr_word[13:12];
         fld_tmp = instr_word[11:10];
         round_opt = instr_word[8];
         instr_size = mau_pkg::MAU_SIZE_SHORT;
         instr_pairable = 1'b1;
      end else if (instr_word[31:24] == mau_pkg::MAU_OPC_LONG && instr_word[1]) begin
         form = mau_pkg::MAU_FORM_LONG;
         fld_src = instr_word[7:6];
         fld_dst = instr_word[5:4];
         fld_tmp = instr_word[3:2];
         round_opt = instr_word[0];
         instr_size = mau_pkg::MAU_SIZE_LONG;
      end else if (instr_word[31:24] == mau_pkg::MAU_OPC_COEF
                   && instr_word[11:10] == mau_pkg::MAU_SUB_COEF) begin
         form = mau_pkg::MAU_FORM_COEF;
         t3_copy = instr_word[15];
         round_opt = instr_word[14];
         fld_dst = instr_word[13:12];
         fld_src = instr_word[13:12];
         instr_size = mau_pkg::MAU_SIZE_MEM;
      end else if (instr_word[31:24] == mau_pkg::MAU_OPC_MEM
                   && instr_word[11:10] == mau_pkg::MAU_SUB_MEM) begin
         form = mau_pkg::MAU_FORM_MEM;
         t3_copy = instr_word[15];
         round_opt = instr_word[14];
         fld_dst = instr_word[13:12];
         fld_src = instr_word[9:8];
         instr_size = mau_pkg::MAU_SIZE_MEM;
      end
   end
   assign instr_legal = (form != mau_pkg::MAU_FORM_NONE);
   logic exec;
   // No busy state: a repeat loop may issue every cycle
   assign exec = instr_valid && instr_legal;
   // ********************************************************************
   // Multiplier
   // ********************************************************************
   logic signed [16:0] op_a, op_b;
   logic [39:0] addend;
   logic signed [33:0] prod;
   logic [34:0] prod_sh;
   logic mul_sat;
   logic [31:0] prod32;
   logic [40:0] prod41;
   // Operand routing per form
   always_comb begin
      op_a = 17'h00000;
      op_b = 17'h00000;
      addend = acc_q[fld_src];
      case (form)
         mau_pkg::MAU_FORM_ACC_TMP: begin
            op_a = acc_q[fld_src][32:16];
            op_b = {tmp_q[fld_tmp][15], tmp_q[fld_tmp]};
            addend = acc_q[fld_dst];
         end
         mau_pkg::MAU_FORM_DST_TMP: begin
            op_a = acc_q[fld_dst][32:16];
            op_b = {tmp_q[fld_tmp][15], tmp_q[fld_tmp]};
            addend = acc_q[fld_src];
         end
         mau_pkg::MAU_FORM_SHORT: begin
            op_a = {tmp_q[fld_tmp][15], tmp_q[fld_tmp]};
            op_b = {{9{instr_word[23]}}, instr_word[23:16]};
         end
         mau_pkg::MAU_FORM_LONG: begin
            op_a = {tmp_q[fld_tmp][15], tmp_q[fld_tmp]};
            op_b = {instr_word[23], instr_word[23:8]};
         end
         mau_pkg::MAU_FORM_COEF: begin
            op_a = {smem_data[15], smem_data};
            op_b = {cmem_data[15], cmem_data};
            addend = acc_q[fld_dst];
         end
         mau_pkg::MAU_FORM_MEM: begin
            op_a = acc_q[fld_src][32:16];
            op_b = {smem_data[15], smem_data};
            addend = acc_q[fld_dst];
         end
         default: op_a = 17'h00000;
      endcase
   end
   assign prod = op_a * op_b;
   // Doubling keeps fractional operands aligned to the accumulator binary point
   assign prod_sh = fractional_mode ? {prod, 1'b0} : {prod[33], prod};
   // Unless an operand is a 17-bit accumulator slice, only the doubled min-by-min product can escape; short form never clamps
   assign mul_sat = multiply_saturation_mode && fractional_mode
                    && form != mau_pkg::MAU_FORM_SHORT
                    && op_a == mau_pkg::MAU_OP_MIN && op_b == mau_pkg::MAU_OP_MIN;
   assign prod32 = mul_sat ? mau_pkg::MAU_PROD_MAX : prod_sh[31:0];
   assign prod41 = {{9{prod32[31]}}, prod32};
   // ********************************************************************
   // Accumulate, round, saturate
   // ********************************************************************
   logic [40:0] sum, sum_r;
   logic rnd_add, add_ovf;
   logic [39:0] result;
   assign sum = {addend[39], addend} + prod41;
   // Biased mode always adds half; unbiased breaks ties toward even
   always_comb begin
      rnd_add = 1'b0;
      if (round_opt) begin
         if (!rounding_mode_select) begin
            rnd_add = 1'b1;
         end else begin
            rnd_add = (sum[15:0] > mau_pkg::MAU_HALF_LSB)
                      || (sum[15:0] == mau_pkg::MAU_HALF_LSB && sum[16]);
         end
      end
   end
   assign sum_r = sum + (rnd_add ? mau_pkg::MAU_RND_HALF : 41'h00000000000);
   // Legacy bit is not consulted; the wide bit alone picks the 40-bit or bit-31 check
   assign add_ovf = wide_overflow_mode ? (sum_r[40] != sum_r[39])
                    : !(&sum_r[40:31] || ~|sum_r[40:31]);
   // Saturate to the limit of the active width, keyed on the true sign
   always_comb begin
      result = sum_r[39:0];
      if (round_opt) begin
         result[15:0] = 16'h0000;
      end
      if (add_ovf && datapath_saturation_enable) begin
         if (wide_overflow_mode) begin
            result = sum_r[40] ? mau_pkg::MAU_SAT40_NEG : mau_pkg::MAU_SAT40_POS;
         end else begin
            result = sum_r[40] ? mau_pkg::MAU_SAT32_NEG : mau_pkg::MAU_SAT32_POS;
         end
      end
   end
   // ********************************************************************
   // AHB-Lite slave
   // ********************************************************************
   logic bus_wr;
   logic [7:0] wr_ofs;
   assign bus_wr = dp_valid_q && dp_write_q;
   assign wr_ofs = dp_addr_q;
   // Capture the address phase whenever the bus is ready
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q <= 8'h00;
      end else if (hready) begin
         dp_valid_q <= hsel && htrans[1];
         dp_write_q <= hwrite;
         dp_addr_q <= {haddr[7:2], 2'b00};
      end
   end
   // Reads take one wait state so they see a write finished just before
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_done_q <= 1'b0;
         hrdata_q <= 32'h00000000;
      end else if (dp_valid_q && !dp_write_q && !rd_done_q) begin
         rd_done_q <= 1'b1;
         hrdata_q <= 32'h00000000;
         if (dp_addr_q == mau_pkg::MAU_CTRL_OFS) begin
            hrdata_q <= {26'h0000000, ctrl_q};
         end else if (dp_addr_q == mau_pkg::MAU_OVF_OFS) begin
            hrdata_q <= {28'h0000000, ovf_q};
         end
         for (int k = 0; k < 4; k++) begin
            if (dp_addr_q == mau_pkg::MAU_ACC_BASE_OFS + 8'(8 * k)) begin
               hrdata_q <= acc_q[k][31:0];
            end
            if (dp_addr_q == mau_pkg::MAU_ACC_BASE_OFS + 8'(8 * k + 4)) begin
               hrdata_q <= {24'h000000, acc_q[k][39:32]};
            end
            if (dp_addr_q == mau_pkg::MAU_TMP_BASE_OFS + 8'(4 * k)) begin
               hrdata_q <= {16'h0000, tmp_q[k]};
            end
         end
      end else begin
         rd_done_q <= 1'b0;
      end
   end
   assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_done_q);
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   // Mode bits other than the legacy bit steer the datapath
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= mau_pkg::MAU_CTRL_RST;
      end else if (bus_wr && wr_ofs == mau_pkg::MAU_CTRL_OFS) begin
         ctrl_q <= hwdata[5:0];
      end
   end
   // ********************************************************************
   // Register file, one copy per entry
   // ********************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_entry
         logic hit;
         assign hit = exec && fld_dst == 2'(gi);
         // Datapath write wins over a bus write in the same cycle
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               acc_q[gi] <= 40'h0000000000;
            end else if (hit) begin
               acc_q[gi] <= result;
            end else if (bus_wr && wr_ofs == mau_pkg::MAU_ACC_BASE_OFS + 8'(8 * gi)) begin
               acc_q[gi][31:0] <= hwdata;
            end else if (bus_wr && wr_ofs == mau_pkg::MAU_ACC_BASE_OFS + 8'(8 * gi + 4)) begin
               acc_q[gi][39:32] <= hwdata[7:0];
            end
         end
         // Sticky flag: a new overflow beats a write-one clear
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               ovf_q[gi] <= 1'b0;
            end else if (hit && add_ovf) begin
               ovf_q[gi] <= 1'b1;
            end else if (bus_wr && wr_ofs == mau_pkg::MAU_OVF_OFS && hwdata[gi]) begin
               ovf_q[gi] <= 1'b0;
            end
         end
         // Temp three also takes the memory operand on request
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               tmp_q[gi] <= 16'h0000;
            end else if (gi == 3 && exec && t3_copy) begin
               tmp_q[gi] <= smem_data;
            end else if (bus_wr && wr_ofs == mau_pkg::MAU_TMP_BASE_OFS + 8'(4 * gi)) begin
               tmp_q[gi] <= hwdata[15:0];
            end
         end
      end
   endgenerate
   // Result report, one cycle after issue
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         res_valid_q <= 1'b0;
         res_dst_q <= 2'h0;
         res_value_q <= 40'h0000000000;
         res_ovf_q <= 1'b0;
      end else begin
         res_valid_q <= exec;
         res_dst_q <= fld_dst;
         res_value_q <= result;
         res_ovf_q <= exec && add_ovf;
      end
   end
   assign result_valid = res_valid_q;
   assign result_dst = res_dst_q;
   assign result_value = res_value_q;
   assign result_overflow = res_ovf_q;
   assign acc_overflow_flags = ovf_q;
   // ********************************************************************
   // Checks
   // ********************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_issue;
      exec && !sys_rst;
   endsequence
   sequence s_report;
      res_valid_q && res_value_q == acc_q[res_dst_q];
   endsequence
   AST_ONE_CYCLE: assert property (s_issue |=> s_report)
      else $error("Result not written one cycle after issue");
   AST_FLAG_SET: assert property (exec && add_ovf |=> ovf_q[$past(fld_dst)])
      else $error("Overflow did not set accumulator flag");
   AST_COEF_FLAG: assert property (exec && form == mau_pkg::MAU_FORM_COEF && add_ovf
         |=> ovf_q[$past(instr_word[13:12])])
      else $error("Coefficient form flag not on its accumulator");
   AST_SAT_POS: assert property (exec && add_ovf && datapath_saturation_enable
         && !wide_overflow_mode && !sum_r[40] |=> res_value_q == 40'h007FFFFFFF)
      else $error("Narrow positive saturation wrong");
   AST_SHORT_NO_MULSAT: assert property (form == mau_pkg::MAU_FORM_SHORT
         |-> prod32 == prod_sh[31:0])
      else $error("Short form clamped product");
   AST_MULSAT_CLAMP: assert property (multiply_saturation_mode && fractional_mode
         && form == mau_pkg::MAU_FORM_LONG && op_a == 17'h18000 && op_b == 17'h18000
         |-> prod32 == 32'h7FFFFFFF)
      else $error("Product saturation missing");
   AST_NO_ROUND: assert property (exec && !round_opt && !add_ovf
         |=> res_value_q == $past(sum[39:0]))
      else $error("Unrounded sum altered");
   AST_ROUND_LOW: assert property (exec && round_opt && !add_ovf
         |=> res_value_q[15:0] == 16'h0000)
      else $error("Rounded result low half not cleared");
   AST_T3_COPY: assert property (exec && t3_copy |=> tmp_q[3] == $past(smem_data))
      else $error("Temp three copy missing");
   AST_FRACT: assert property (fractional_mode |-> prod_sh[0] == 1'b0)
      else $error("Fractional product not doubled");
   AST_READ_WAIT: assert property (dp_valid_q && !dp_write_q && !rd_done_q
         |-> !hreadyout ##1 hreadyout)
      else $error("Read wait state wrong");

endmodule

// [bench/mau_dec_model.sv]
// Purpose: Decoder and operand fetch model feeding the multiply-accumulate unit
// Assumes: Caller stands just after a rising edge when it calls a task
// Notes: Released operand lines show the inverse of their last value

`timescale 1ns/1ns

// ********************************************************************
// Decoder model
// ********************************************************************
module mau_dec_model (
   input wire logic clk,
   output logic instr_valid,
   output logic [31:0] instr_word,
   output logic [15:0] smem_data,
   output logic [15:0] cmem_data
);
   // Quiet bus until the first issue
   initial begin
      instr_valid = 1'b0;
      instr_word = 32'h0;
      smem_data = 16'h0;
      cmem_data = 16'h0;
   end

   // One word per call; calls on successive edges give repeat-loop traffic
   task automatic drive(input logic [31:0] w, input logic [15:0] sm, input logic [15:0] cm);
      instr_valid <= 1'b1;
      instr_word <= w;
      smem_data <= sm;
      cmem_data <= cm;
   endtask

   // Released lines flip so a stale value is never mistaken for data
   task automatic idle();
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
      smem_data <= ~smem_data;
      cmem_data <= ~cmem_data;
   endtask
endmodule

// [bench/tb.sv]
// Purpose: Self-checking bench for the multiply-accumulate unit
// Assumes: One AHB-Lite slave, so hready follows hreadyout
// Notes: Reference model keeps accumulators, temps and flags

`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin err_total++; \
   $display("[ERR] %s exp %0h got %0h", n, e, s); end end

// ********************************************************************
// Bench
// ********************************************************************
module tb;
   logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, iv, il, ip, rv, ro;
   logic due_q = 0;
   logic [15:0] smd, cmd;
   logic [31:0] wrd;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, iw, rd;
   logic [1:0] htrans = 0, rdst;
   logic [2:0] hsize = 3'h2, isz;
   logic [39:0] rval, acc_m [4];
   logic [15:0] sm, cm, tmp_m [4];
   logic [3:0] aflg, flg_m = 0;
   logic [5:0] ctrl_m;
   logic [46:0] e, exp_q [$];
   logic [2:0] sz [6] = '{3'h2, 3'h2, 3'h3, 3'h4, 3'h3, 3'h3};
   logic [31:0] msk [7] = '{32'h01FDFFFF, 32'h01FDFFFF, 32'h01FFFDFF, 32'h00FFFFFD,
      32'h00FFF3FF, 32'h00FFF3FF, 32'h00FFF3FF};
   logic [31:0] pat [7] = '{32'h56000000, 32'h58020000, 32'h1E000200, 32'h79000002,
      32'hD1000400, 32'hD2000000, 32'hD1000800};
   int err_total = 0, comparisons = 0, seed = 32'h20B754AB, f, n, j;

   always #20 clk = ~clk;

   mau_dec_model u_dec (.clk(clk), .instr_valid(iv), .instr_word(iw), .smem_data(smd),
      .cmem_data(cmd));
   mau_core u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(iv),
      .instr_word(iw), .smem_data(smd), .cmem_data(cmd),
      .instr_legal(il), .instr_size(isz), .instr_pairable(ip), .result_valid(rv),
      .result_dst(rdst), .result_value(rval), .result_overflow(ro),
      .acc_overflow_flags(aflg));

   // Single word transfer; waits on the bus handshake at each phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Corner value 8000 often, so the saturated product case gets hit
   function automatic logic [15:0] p16();
      return ($random(seed) & 3) ? 16'($random(seed)) : 16'h8000;
   endfunction

   // Reference model of one executed instruction
   task automatic exec(input int f, input logic [31:0] w);
      logic [16:0] x, y;
      logic [15:0] t;
      logic [1:0] d, s;
      logic r, ov;
      logic [40:0] sum;
      logic [39:0] v, ac;
      logic [31:0] p;
      longint pr;
      d = f < 2 ? w[23:22] : f == 3 ? w[5:4] : w[13:12];
      s = f < 2 ? w[21:20] : f == 2 ? w[15:14] : f == 3 ? w[7:6] : f == 4 ? d : w[9:8];
      r = f < 2 ? w[16] : f == 2 ? w[8] : f == 3 ? w[0] : w[14];
      t = f < 2 ? tmp_m[w[19:18]] : f == 2 ? tmp_m[w[11:10]] : tmp_m[w[3:2]];
      x = f == 1 ? acc_m[d][32:16] : f == 2 || f == 3 ? {t[15], t} :
         f == 4 ? {sm[15], sm} : acc_m[s][32:16];
      y = f < 2 ? {t[15], t} : f == 2 ? {{9{w[23]}}, w[23:16]} : f == 3 ? {w[23], w[23:8]} :
         f == 4 ? {cm[15], cm} : {sm[15], sm};
      ac = f == 0 || f == 5 ? acc_m[d] : acc_m[s];
      pr = $signed(x) * $signed(y) <<< ctrl_m[0];
      p = pr[31:0];
      if (ctrl_m[1:0] == 2'b11 && f != 2 && x == 17'h18000 && y == 17'h18000) begin
         p = 32'h7FFFFFFF;
      end
      sum = {{9{p[31]}}, p} + {ac[39], ac};
      if (r && (!ctrl_m[2] || sum[15:0] > 16'h8000 || sum[16:0] == 17'h18000)) begin
         sum = sum + 41'h8000;
      end
      if (r) sum[15:0] = 16'h0;
      ov = ctrl_m[3] ? sum[40] != sum[39] : sum[40:31] != '0 && sum[40:31] != '1;
      v = sum[39:0];
      if (ov && ctrl_m[4]) v = ctrl_m[3] ? (sum[40] ? 40'h8000000000 : 40'h7FFFFFFFFF) :
         (sum[40] ? 40'hFF80000000 : 40'h007FFFFFFF);
      acc_m[d] = v;
      flg_m[d] = flg_m[d] | ov;
      if (f > 3 && w[15]) tmp_m[3] = sm;
      exp_q.push_back({flg_m, d, ov, v});
   endtask

   // Result watcher: one pulse exactly one cycle after each executed word
   always @(posedge clk) begin
      if (sys_rst === 1'b0) begin
         `CHK("result_valid", due_q, rv)
         if (due_q) begin
            e = exp_q.pop_front();
            `CHK("result_value", e[39:0], rval)
            `CHK("result_overflow", e[40], ro)
            `CHK("result_dst", e[42:41], rdst)
            `CHK("flags", e[46:43], aflg)
         end
         // Entries left after the pop belong to the word executing at this edge
         due_q = (exp_q.size() != 0);
      end
   end

   task automatic print_verdict();
      if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard, about six times the expected run
   initial begin
      #800000;
      err_total++;
      print_verdict();
   end

   // Main sequence: reset values, then random bursts with readback
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      ahb(1'b1, 8'hFC, 32'hFFFFFFFF);
      for (n = 0; n < 3; n++) begin
         ahb(1'b0, n == 2 ? 8'hFC : 8'(4 * n), 32'h0);
         `CHK("reset_or_unmapped", 32'h0, rd)
      end
      for (j = 0; j < 50; j++) begin
         ctrl_m = 6'($random(seed));
         ahb(1'b1, 8'h00, {26'h0, ctrl_m});
         ahb(1'b0, 8'h00, 32'h0);
         `CHK("ctrl", {26'h0, ctrl_m}, rd)
         for (n = 0; n < 4; n++) begin
            acc_m[n] = ($random(seed) & 3) ? {8'($random(seed)), 32'($random(seed))} :
               40'hFF80000000;
            tmp_m[n] = p16();
            ahb(1'b1, 8'(8'h10 + 8 * n), acc_m[n][31:0]);
            ahb(1'b1, 8'(8'h14 + 8 * n), {24'h0, acc_m[n][39:32]});
            ahb(1'b1, 8'(8'h30 + 4 * n), {16'h0, tmp_m[n]});
         end
         repeat (1 + ($unsigned($random(seed)) % 6)) begin
            f = $unsigned($random(seed)) % 7;
            wrd = (32'($random(seed)) & msk[f]) | pat[f];
            sm = p16();
            cm = p16();
            u_dec.drive(wrd, sm, cm);
            @(negedge clk);
            `CHK("instr_legal", f < 6, il)
            `CHK("instr_size", f < 6 ? sz[f] : 3'h0, isz)
            `CHK("instr_pairable", f < 3, ip)
            if (f < 6) exec(f, wrd);
            @(posedge clk);
         end
         u_dec.idle();
         repeat (2) @(posedge clk);
         for (n = 0; n < 4; n++) begin
            ahb(1'b0, 8'(8'h10 + 8 * n), 32'h0);
            `CHK("acc_lo", acc_m[n][31:0], rd)
            ahb(1'b0, 8'(8'h14 + 8 * n), 32'h0);
            `CHK("acc_hi", {24'h0, acc_m[n][39:32]}, rd)
         end
         ahb(1'b0, 8'h3C, 32'h0);
         `CHK("temp3", {16'h0, tmp_m[3]}, rd)
         ahb(1'b0, 8'h04, 32'h0);
         `CHK("flag_reg", {28'h0, flg_m}, rd)
         ahb(1'b1, 8'h04, 32'hF);
         flg_m = 4'h0;
      end
      print_verdict();
   end
endmodule
